// ===== dv/flash_far_model.sv
`timescale 1ns/1ps
// array engine and serial lock receiver beyond the block
module flash_far_model
  import flash_protect_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic array_req,
  input wire logic [1:0] array_kind,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic lock_so,
  input wire logic lock_so_valid,
  output logic [15:0] req_cnt_q,
  output logic [1:0] kind_q,
  output logic [ADDR_W-1:0] addr_q,
  output logic [7:0] field_q
);
  // engine counts pulses; field shifts in msb first, so eight bits replace it whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_cnt_q <= 16'h0;
      kind_q <= 2'h0;
      addr_q <= '0;
      field_q <= 8'h0;
    end else begin
      if (array_req) begin
        req_cnt_q <= req_cnt_q + 16'h1;
        kind_q <= array_kind;
        addr_q <= array_addr;
      end
      if (lock_so_valid) begin
        field_q <= {field_q[6:0], lock_so};
      end
    end
  end
endmodule : flash_far_model

// ===== dv/flash_protect_sva.sv
`timescale 1ns/1ps
module flash_protect_sva
  import flash_protect_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic array_req,
  input wire logic [1:0] array_kind,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic lock_so,
  input wire logic lock_so_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // upper seven field bits carry no state, only the last one does
  sequence field_upper_zero;
    (!lock_so) [*7];
  endsequence

  AST_FIELD_LEN: assert property ($rose(lock_so_valid) |-> lock_so_valid [*8] ##1 !lock_so_valid)
    else $error("lock field not eight cycles long");
  AST_FIELD_UPPER: assert property ($rose(lock_so_valid) |-> field_upper_zero)
    else $error("lock field upper bits not zero");
  AST_FIELD_WITH_RESP: assert property ($rose(lock_so_valid) |-> $rose(bvalid))
    else $error("lock field not started by a command");
  AST_REQ_ONE: assert property (array_req |=> !array_req)
    else $error("array request longer than one cycle");
  AST_REQ_WITH_RESP: assert property (array_req |-> $rose(bvalid))
    else $error("array request without command write");
  AST_ALIGN_64K: assert property (array_req && array_kind == 2'h3 |-> array_addr[15:0] == 16'h0)
    else $error("64k erase address not aligned");
  AST_ALIGN_32K: assert property (array_req && array_kind == 2'h2 |-> array_addr[14:0] == 15'h0)
    else $error("32k erase address not aligned");
  AST_KIND_HOLD: assert property (!array_req |-> $stable(array_kind) && $stable(array_addr))
    else $error("array kind or address moved without request");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !array_req && !lock_so_valid)
    else $error("outputs active after reset");
endmodule : flash_protect_sva

bind flash_array_write_protection flash_protect_sva chk_u (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .rvalid(rvalid), .array_req(array_req),
  .array_kind(array_kind), .array_addr(array_addr), .lock_so(lock_so),
  .lock_so_valid(lock_so_valid)
);

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flash_protect_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, array_req, lock_so, lock_so_valid;
  logic [7:0] awaddr, araddr, far_field;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, array_kind, far_kind, resp_q;
  logic [ADDR_W-1:0] array_addr, far_addr;
  logic [15:0] far_cnt;
  int n_fail, samples_checked;

  flash_array_write_protection dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .array_req(array_req), .array_kind(array_kind), .array_addr(array_addr),
    .lock_so(lock_so), .lock_so_valid(lock_so_valid));
  flash_far_model far_u (.aclk(aclk), .aresetn(aresetn), .array_req(array_req),
    .array_kind(array_kind), .array_addr(array_addr), .lock_so(lock_so),
    .lock_so_valid(lock_so_valid), .req_cnt_q(far_cnt), .kind_q(far_kind), .addr_q(far_addr),
    .field_q(far_field));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // one bus transfer; ready sampled at negedge, so it equals the value at the next edge
  task automatic axi_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, ar_ok, done;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    ar_ok = 1'b0;
    done = 1'b0;
    n = 0;
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && n < 40) begin
      @(negedge aclk);
      n++;
      if (awvalid && awready) aw_ok = 1'b1;
      if (wvalid && wready) w_ok = 1'b1;
      if (arvalid && arready) ar_ok = 1'b1;
      done = wr ? bvalid : rvalid;
      resp_q = wr ? bresp : rresp;
      rd_q = rdata;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (ar_ok) arvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
    end
    // one spare edge: partner counters settle, next call never re-drives in this step
    @(posedge aclk);
    if (!done) begin
      n_fail++;
      complete_run();
    end
  endtask : axi_xfer

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_xfer(1'b0, a, 32'h0);
    compare(what, exp, rd_q);
  endtask : rd_chk

  task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
    axi_xfer(1'b1, OFS_CMD_ADDR, {8'h00, addr});
    axi_xfer(1'b1, OFS_CMD, {24'h0, op});
  endtask : cmd

  // one decision: pulse count, kind, aligned footprint and result flags
  task automatic try_op(input logic [7:0] op, input logic [23:0] addr, input logic ok);
    logic [15:0] c0;
    logic [18:0] m;
    logic [1:0] k;
    c0 = far_cnt;
    case (op)
      OP_PROGRAM: begin m = 19'h000ff; k = 2'h0; end
      OP_ERASE_4K: begin m = 19'h00fff; k = 2'h1; end
      OP_ERASE_32K: begin m = 19'h07fff; k = 2'h2; end
      default: begin m = 19'h0ffff; k = 2'h3; end
    endcase
    cmd(op, addr);
    compare("pulses", 32'(c0) + 32'(ok), 32'(far_cnt));
    if (ok) compare("kind", 32'(k), 32'(far_kind));
    if (ok) compare("addr", 32'(addr[18:0] & ~m), 32'(far_addr));
    rd_chk("result", OFS_RESULT, ok ? 32'h1 : 32'h2);
  endtask : try_op

  task automatic run_case(input logic [7:0] cfg, input logic inv, input logic [7:0] op,
                          input logic [23:0] addr, input logic ok);
    axi_xfer(1'b1, OFS_PROT_CFG, {24'h0, cfg});
    axi_xfer(1'b1, OFS_INVERT, {25'h0, inv, 6'h0});
    try_op(op, addr, ok);
  endtask : run_case

  // main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("scheme", OFS_SCHEME, 32'h0);
    rd_chk("lock lo", OFS_LOCK_LO, 32'hffffffff);
    rd_chk("lock hi", OFS_LOCK_HI, 32'h3f);
    try_op(OP_PROGRAM, 24'h07ff00, 1'b1);
    $display("test reset done");
    run_case(8'h04, 1'b0, OP_PROGRAM, 24'h070000, 1'b0);
    run_case(8'h04, 1'b0, OP_PROGRAM, 24'h06ff00, 1'b1);
    run_case(8'h24, 1'b0, OP_PROGRAM, 24'h00ff00, 1'b0);
    run_case(8'h2c, 1'b0, OP_PROGRAM, 24'h040000, 1'b1);
    run_case(8'h10, 1'b0, OP_PROGRAM, 24'h000000, 1'b0);
    run_case(8'h00, 1'b0, OP_ERASE_64K, 24'h000000, 1'b1);
    run_case(8'h44, 1'b0, OP_PROGRAM, 24'h07ef00, 1'b1);
    run_case(8'h54, 1'b0, OP_ERASE_4K, 24'h078000, 1'b0);
    run_case(8'h70, 1'b0, OP_PROGRAM, 24'h008000, 1'b1);
    run_case(8'h78, 1'b0, OP_PROGRAM, 24'h040000, 1'b0);
    run_case(8'h04, 1'b1, OP_PROGRAM, 24'h06ff00, 1'b0);
    run_case(8'h04, 1'b1, OP_ERASE_64K, 24'h070000, 1'b1);
    run_case(8'h3c, 1'b1, OP_PROGRAM, 24'h000000, 1'b1);
    run_case(8'h44, 1'b1, OP_PROGRAM, 24'h07f000, 1'b1);
    run_case(8'h6c, 1'b1, OP_PROGRAM, 24'h004000, 1'b0);
    run_case(8'h40, 1'b1, OP_PROGRAM, 24'h07ff00, 1'b0);
    run_case(8'h44, 1'b1, OP_ERASE_32K, 24'h078000, 1'b1);
    run_case(8'h64, 1'b1, OP_ERASE_32K, 24'h000000, 1'b1);
    run_case(8'h44, 1'b1, OP_ERASE_64K, 24'h075000, 1'b1);
    run_case(8'h68, 1'b1, OP_ERASE_64K, 24'h010000, 1'b0);
    run_case(8'h64, 1'b1, OP_ERASE_4K, 24'h001000, 1'b0);
    $display("test range done");
    axi_xfer(1'b1, OFS_SCHEME, 32'h4);
    try_op(OP_PROGRAM, 24'h000100, 1'b0);
    cmd(OP_UNLOCK, 24'h005000);
    rd_chk("lock lo", OFS_LOCK_LO, 32'hffffffdf);
    try_op(OP_PROGRAM, 24'h005a00, 1'b1);
    try_op(OP_ERASE_4K, 24'h006000, 1'b0);
    cmd(OP_UNLOCK, 24'h07e123);
    rd_chk("lock lo", OFS_LOCK_LO, 32'hbfffffdf);
    cmd(OP_UNLOCK, 24'h023456);
    rd_chk("lock hi", OFS_LOCK_HI, 32'h3d);
    try_op(OP_ERASE_64K, 24'h02ffff, 1'b1);
    cmd(OP_LOCK, 24'h020000);
    try_op(OP_ERASE_64K, 24'h020000, 1'b0);
    cmd(OP_READ_LOCK_B, 24'h020000);
    repeat (10) @(posedge aclk);
    compare("field", 32'h1, 32'(far_field));
    cmd(OP_GLOBAL_UNLOCK, 24'h0);
    rd_chk("lock lo", OFS_LOCK_LO, 32'h0);
    rd_chk("lock hi", OFS_LOCK_HI, 32'h0);
    axi_xfer(1'b1, OFS_PROT_CFG, 32'h10);
    try_op(OP_PROGRAM, 24'h040000, 1'b1);
    cmd(OP_READ_LOCK_B, 24'h040000);
    repeat (10) @(posedge aclk);
    compare("field", 32'h0, 32'(far_field));
    cmd(OP_GLOBAL_LOCK, 24'h0);
    rd_chk("lock lo", OFS_LOCK_LO, 32'hffffffff);
    rd_chk("lock hi", OFS_LOCK_HI, 32'h3f);
    cmd(OP_READ_LOCK_A, 24'h040000);
    repeat (10) @(posedge aclk);
    compare("field", 32'h1, 32'(far_field));
    rd_chk("lock field", OFS_LOCK_FIELD, 32'h1);
    try_op(OP_ERASE_32K, 24'h078000, 1'b0);
    $display("test lock done");
    axi_xfer(1'b0, 8'h40, 32'h0);
    compare("rresp", 32'(RESP_SLVERR), 32'(resp_q));
    compare("rdata", 32'h0, rd_q);
    axi_xfer(1'b1, 8'h40, 32'h1);
    compare("bresp", 32'(RESP_SLVERR), 32'(resp_q));
    $display("test unmapped done");
    complete_run();
  end
endmodule : testbench

// ===== rtl/flash_array_write_protection.sv
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module flash_array_write_protection
  import flash_protect_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic array_req,
  output logic [1:0] array_kind,
  output logic [ADDR_W-1:0] array_addr,
  output logic lock_so,
  output logic lock_so_valid
);

  // protection configuration
  logic [2:0] extent_q, extent_d;
  logic granule_q, granule_d;
  logic bottom_q, bottom_d;
  logic invert_q, invert_d;
  logic scheme_q, scheme_d;
  logic [NUM_LOCK-1:0] lock_q, lock_d;
  logic [23:0] cmd_addr_q, cmd_addr_d;
  logic [2:0] result_q, result_d;
  logic [7:0] lock_field_q, lock_field_d;
  // bus slave state
  logic aw_hold_q, aw_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic w_hold_q, w_hold_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // array request and serial lock output
  logic req_q, req_d;
  op_kind_t kind_q, kind_d;
  logic [ADDR_W-1:0] req_addr_q, req_addr_d;
  shift_state_t sh_state_q, sh_state_d;
  logic [2:0] sh_cnt_q, sh_cnt_d;
  logic [7:0] sh_q, sh_d;
  // combinational helpers
  logic do_write;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] op_addr;
  logic [5:0] op_lock_idx;
  logic is_array_op;
  op_kind_t op_kind;
  logic [19:0] op_size;
  logic [19:0] op_lo;
  logic [19:0] op_hi;
  logic [19:0] ext_size;
  logic [19:0] free_size;
  logic [19:0] prot_size;
  logic prot_at_top;
  logic std_hit;
  logic lock_hit;
  logic op_blocked;

  // lock bit index covering one address: bottom 4 kB, top 4 kB, middle 64 kB
  function automatic logic [5:0] lock_index(input logic [ADDR_W-1:0] a);
    if (a[18:16] == 3'h7) return {2'h1, a[15:12]};
    if (a[18:16] != 3'h0) return 6'h1f + {3'h0, a[18:16]};
    return {2'h0, a[15:12]};
  endfunction : lock_index

  // first byte covered by a lock bit
  function automatic logic [19:0] lock_base(input int i);
    if (i < 16) return 20'(i) * SZ_4K;
    if (i < 32) return TOP_BLOCK_BASE + 20'(i - 16) * SZ_4K;
    return 20'(i - 31) * SZ_64K;
  endfunction : lock_base

  // write taken once both halves are held and no response is pending
  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_ofs = {awaddr_q[7:2], 2'h0};
  assign rd_ofs = {araddr[7:2], 2'h0};
  assign opcode = wdata_q[7:0];
  assign op_addr = cmd_addr_q[ADDR_W-1:0];
  assign op_lock_idx = lock_index(op_addr);

  // sort the command into an array operation and its erase footprint
  always_comb begin
    is_array_op = 1'b1;
    op_kind = KIND_PROGRAM;
    op_size = SZ_PAGE;
    unique case (opcode)
      OP_ERASE_4K: begin // RL21
        op_kind = KIND_ERASE_4K;
        op_size = SZ_4K;
      end
      OP_ERASE_32K: begin // RL21
        op_kind = KIND_ERASE_32K;
        op_size = SZ_32K;
      end
      OP_ERASE_64K: begin // RL21
        op_kind = KIND_ERASE_64K;
        op_size = SZ_64K;
      end
      OP_PROGRAM: is_array_op = 1'b1; // page kind and size from the defaults
      default: begin
        is_array_op = 1'b0;
      end
    endcase
    op_lo = {1'b0, op_addr} & ~(op_size - 20'h1);
    op_hi = op_lo + op_size - 20'h1;
  end

  // extent field to a byte size; zero means nothing, array size means all
  always_comb begin
    ext_size = ARRAY_SIZE;
    if (!granule_q) begin // RL3
      unique case (extent_q) // RL6 RL8
        3'h0: ext_size = 20'h0;
        3'h1: ext_size = SZ_64K;
        3'h2: ext_size = SZ_128K;
        3'h3: ext_size = SZ_256K;
        default: ext_size = ARRAY_SIZE;
      endcase
    end else begin
      unique case (extent_q) // RL7 RL9
        3'h0: ext_size = 20'h0;
        3'h1: ext_size = SZ_4K;
        3'h2: ext_size = SZ_8K;
        3'h3: ext_size = SZ_16K;
        3'h4: ext_size = SZ_32K;
        3'h5: ext_size = SZ_32K;
        default: ext_size = ARRAY_SIZE;
      endcase
    end
  end

  // range scheme: inverted map protects all but the free stretch
  always_comb begin
    free_size = ext_size;
    if (invert_q && granule_q && ext_size != 20'h0 && ext_size != ARRAY_SIZE) begin
      // block erases cannot split their own block, so the free end grows
      if (op_kind == KIND_ERASE_32K && free_size < SZ_32K) free_size = SZ_32K; // RL10
      if (op_kind == KIND_ERASE_64K && free_size < SZ_64K) free_size = SZ_64K; // RL11
    end
    prot_size = invert_q ? ARRAY_SIZE - free_size : ext_size; // RL2
    prot_at_top = (bottom_q == invert_q); // RL4 RL2
    std_hit = 1'b0;
    if (prot_size != 20'h0) begin // RL5
      std_hit = prot_at_top ? (op_hi >= ARRAY_SIZE - prot_size) : (op_lo < prot_size);
    end
  end

  // lock scheme: any covering lock bit bars the whole operation
  always_comb begin
    lock_hit = 1'b0;
    for (int i = 0; i < NUM_LOCK; i++) begin
      if (lock_q[i] && lock_base(i) <= op_hi &&
          lock_base(i) + ((i >= 32) ? SZ_64K : SZ_4K) > op_lo) begin
        lock_hit = 1'b1;
      end
    end
  end

  // range fields play no part while lock bits are in charge
  assign op_blocked = scheme_q ? lock_hit : std_hit; // RL1 RL23

  // register writes, command execution and the write responses
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d = awaddr_q;
    w_hold_d = w_hold_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    extent_d = extent_q;
    granule_d = granule_q;
    bottom_d = bottom_q;
    invert_d = invert_q;
    scheme_d = scheme_q;
    lock_d = lock_q;
    cmd_addr_d = cmd_addr_q;
    result_d = result_q;
    lock_field_d = lock_field_q;
    req_d = 1'b0;
    kind_d = kind_q;
    req_addr_d = req_addr_q;
    sh_state_d = sh_state_q;
    sh_cnt_d = sh_cnt_q;
    sh_d = sh_q;
    if (awvalid && awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // serial lock field, one bit per clock, msb first
    if (sh_state_q == SH_SHIFT) begin // RL19
      sh_d = {sh_q[6:0], 1'b0};
      sh_cnt_d = sh_cnt_q + 3'h1;
      if (sh_cnt_q == SHIFT_LAST) sh_state_d = SH_IDLE;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (wr_ofs)
        OFS_PROT_CFG: begin
          if (wstrb_q[0]) begin
            extent_d = wdata_q[EXTENT_LSB +: 3];
            granule_d = wdata_q[GRANULE_BIT];
            bottom_d = wdata_q[BOTTOM_BIT];
          end
        end
        OFS_INVERT: begin
          if (wstrb_q[0]) begin
            invert_d = wdata_q[INVERT_BIT];
          end
        end
        OFS_SCHEME: begin
          if (wstrb_q[0]) begin
            scheme_d = wdata_q[SCHEME_BIT];
          end
        end
        OFS_CMD_ADDR: begin
          for (int b = 0; b < 3; b++) begin
            if (wstrb_q[b]) begin
              cmd_addr_d[8*b +: 8] = wdata_q[8*b +: 8];
            end
          end
        end
        OFS_CMD: begin
          if (wstrb_q[0]) begin
            result_d = 3'h0;
            if (opcode == OP_LOCK) begin
              lock_d[op_lock_idx] = 1'b1; // RL12 RL13
            end else if (opcode == OP_UNLOCK) begin
              lock_d[op_lock_idx] = 1'b0; // RL12 RL13
            end else if (opcode == OP_GLOBAL_LOCK) begin
              lock_d = {NUM_LOCK{1'b1}}; // RL14
            end else if (opcode == OP_GLOBAL_UNLOCK) begin
              lock_d = {NUM_LOCK{1'b0}}; // RL14
            end else if (opcode == OP_READ_LOCK_A || opcode == OP_READ_LOCK_B) begin // RL18
              lock_field_d = {7'h0, lock_q[op_lock_idx]}; // RL20
              sh_d = {7'h0, lock_q[op_lock_idx]};
              sh_cnt_d = 3'h0;
              sh_state_d = SH_SHIFT; // RL19
            end else if (is_array_op) begin
              // a barred request is dropped here and never reaches the array
              if (op_blocked) begin // RL22 RL17
                result_d[RES_REJECTED_BIT] = 1'b1;
              end else begin
                result_d[RES_GRANTED_BIT] = 1'b1;
                req_d = 1'b1;
                kind_d = op_kind;
                req_addr_d = op_lo[ADDR_W-1:0];
              end
            end else begin
              result_d[RES_UNKNOWN_BIT] = 1'b1;
            end
          end
        end
        OFS_RESULT, OFS_LOCK_FIELD, OFS_LOCK_LO, OFS_LOCK_HI: begin
          bresp_d = RESP_OKAY;
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  // read channel: data captured at the address handshake
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0;
      unique case (rd_ofs)
        OFS_PROT_CFG: begin
          rdata_d[EXTENT_LSB +: 3] = extent_q;
          rdata_d[GRANULE_BIT] = granule_q;
          rdata_d[BOTTOM_BIT] = bottom_q;
        end
        OFS_INVERT: rdata_d[INVERT_BIT] = invert_q;
        OFS_SCHEME: rdata_d[SCHEME_BIT] = scheme_q;
        OFS_CMD_ADDR: rdata_d[23:0] = cmd_addr_q;
        OFS_CMD: rdata_d = 32'h0;
        OFS_RESULT: rdata_d[2:0] = result_q;
        OFS_LOCK_FIELD: rdata_d[7:0] = lock_field_q; // RL20
        OFS_LOCK_LO: rdata_d = lock_q[31:0];
        OFS_LOCK_HI: rdata_d[5:0] = lock_q[NUM_LOCK-1:32];
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // state registers; lock bits come up set, scheme comes up range-based
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h0;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
      extent_q <= EXTENT_RST;
      granule_q <= GRANULE_RST;
      bottom_q <= BOTTOM_RST;
      invert_q <= INVERT_RST;
      scheme_q <= SCHEME_RST; // RL16
      lock_q <= LOCK_RST; // RL15
      cmd_addr_q <= 24'h0;
      result_q <= 3'h0;
      lock_field_q <= 8'h0;
      req_q <= 1'b0;
      kind_q <= KIND_PROGRAM;
      req_addr_q <= '0;
      sh_state_q <= SH_IDLE;
      sh_cnt_q <= 3'h0;
      sh_q <= 8'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      awaddr_q <= awaddr_d;
      w_hold_q <= w_hold_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      extent_q <= extent_d;
      granule_q <= granule_d;
      bottom_q <= bottom_d;
      invert_q <= invert_d;
      scheme_q <= scheme_d;
      lock_q <= lock_d;
      cmd_addr_q <= cmd_addr_d;
      result_q <= result_d;
      lock_field_q <= lock_field_d;
      req_q <= req_d;
      kind_q <= kind_d;
      req_addr_q <= req_addr_d;
      sh_state_q <= sh_state_d;
      sh_cnt_q <= sh_cnt_d;
      sh_q <= sh_d;
    end
  end

  // outputs straight from flops
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign array_req = req_q;
  assign array_kind = kind_q;
  assign array_addr = req_addr_q;
  assign lock_so = sh_q[7];
  assign lock_so_valid = (sh_state_q == SH_SHIFT);

endmodule : flash_array_write_protection

// ===== rtl/flash_protect_pkg.sv
// Behaviour
// RL1: scheme bit picks range or lock-bit protection
// RL2: invert bit swaps protected and writable areas
// RL3: granule bit picks 64 kB or 4 kB units
// RL4: direction bit picks top-down or bottom-up range
// RL5: program/erase inside selected extent is rejected
// RL6: invert 0, 64 kB: none, top/bottom sizes, all
// RL7: invert 0, 4 kB: 4..32 kB ranges, all, none
// RL8: invert 1, 64 kB: all, all-but-range, none
// RL9: invert 1, 4 kB: leave 4..32 kB free
// RL10: 32 kB erase widens free area to 32 kB
// RL11: 64 kB erase widens free area to 64 kB
// RL12: lock/unlock opcodes set/clear addressed block bit
// RL13: 38 lock bits: 16 top, 16 bottom, 6 middle
// RL14: global lock sets, global unlock clears all bits
// RL15: all lock bits reset to locked
// RL16: scheme bit resets to range scheme, unprotected
// RL17: host unlocks blocks before program or erase
// RL18: both lock-read opcodes behave identically
// RL19: lock field shifted out msb first
// RL20: lock field lsb is one when locked
// RL21: erase opcodes select 64, 32, 4 kB sizes
// RL22: rejected program or erase never reaches array
// RL23: range fields ignored under lock-bit scheme
package flash_protect_pkg;

  // array geometry, byte sizes kept 20 bits wide for overflow-free sums
  localparam int ADDR_W = 19;
  localparam int NUM_LOCK = 38;
  localparam logic [19:0] ARRAY_SIZE = 20'h80000;
  localparam logic [19:0] SZ_PAGE = 20'h00100;
  localparam logic [19:0] SZ_4K = 20'h01000;
  localparam logic [19:0] SZ_8K = 20'h02000;
  localparam logic [19:0] SZ_16K = 20'h04000;
  localparam logic [19:0] SZ_32K = 20'h08000;
  localparam logic [19:0] SZ_64K = 20'h10000;
  localparam logic [19:0] SZ_128K = 20'h20000;
  localparam logic [19:0] SZ_256K = 20'h40000;
  localparam logic [19:0] TOP_BLOCK_BASE = 20'h70000;

  // register byte offsets
  localparam logic [7:0] OFS_PROT_CFG = 8'h00;
  localparam logic [7:0] OFS_INVERT = 8'h04;
  localparam logic [7:0] OFS_SCHEME = 8'h08;
  localparam logic [7:0] OFS_CMD_ADDR = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_LOCK_FIELD = 8'h18;
  localparam logic [7:0] OFS_LOCK_LO = 8'h1c;
  localparam logic [7:0] OFS_LOCK_HI = 8'h20;

  // field positions
  localparam int GRANULE_BIT = 6;
  localparam int BOTTOM_BIT = 5;
  localparam int EXTENT_LSB = 2;
  localparam int INVERT_BIT = 6;
  localparam int SCHEME_BIT = 2;
  localparam int RES_GRANTED_BIT = 0;
  localparam int RES_REJECTED_BIT = 1;
  localparam int RES_UNKNOWN_BIT = 2;

  // reset values
  localparam logic [NUM_LOCK-1:0] LOCK_RST = {NUM_LOCK{1'b1}};
  localparam logic [2:0] EXTENT_RST = 3'h0;
  localparam logic GRANULE_RST = 1'b0;
  localparam logic BOTTOM_RST = 1'b0;
  localparam logic INVERT_RST = 1'b0;
  localparam logic SCHEME_RST = 1'b0;

  // opcodes
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_READ_LOCK_A = 8'h3c;
  localparam logic [7:0] OP_READ_LOCK_B = 8'h3d;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SHIFT_LAST = 3'h7;

  typedef enum logic [1:0] {
    KIND_PROGRAM = 2'h0,
    KIND_ERASE_4K = 2'h1,
    KIND_ERASE_32K = 2'h2,
    KIND_ERASE_64K = 2'h3
  } op_kind_t;

  typedef enum logic {
    SH_IDLE = 1'b0,
    SH_SHIFT = 1'b1
  } shift_state_t;

endpackage : flash_protect_pkg
